// >>> bench/mms_memory_select_assertions.sv
`timescale 1ns/1ps
// ****
// Select checker
// ****
module mms_sel_assertions (
  // Clock, reset, bus and mode
  input wire logic mclk, rst, standalone,
  input wire logic [mms_pkg::ADDR_W-1:0] bus_addr,
  // Presets and selects
  input wire logic [mms_pkg::RAM_PRESET_W-1:0] ram_preset,
  input wire logic [mms_pkg::ROM_PRESET_W-1:0] rom_preset,
  input wire logic ram_card_disable_n, rom_card_disable_n, ram_card_sel_n_oe,
  input wire logic rom_card_sel_n_oe, shared_card_select_n_i,
  // Results
  input wire logic power_on_init, oncard_ram_en, oncard_rom_en, buffered_write_strobe
);
  import mms_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Card decode and strobe gating
  a_ram_decode: assert property (ram_card_sel_n_oe ==
    (ram_card_disable_n && bus_addr[15:11] == ram_preset)) else $error("ram select");
  a_rom_decode: assert property (rom_card_sel_n_oe ==
    (rom_card_disable_n && bus_addr[15:12] == rom_preset)) else $error("rom select");
  a_disable_wins: assert property (!ram_card_disable_n |-> !ram_card_sel_n_oe)
    else $error("disable");
  a_write_gated: assert property (buffered_write_strobe |-> ram_card_sel_n_oe)
    else $error("write strobe");
  // On-card memory gating
  a_oncard_lockout: assert property ((!standalone && !shared_card_select_n_i) [*3] |->
    !oncard_ram_en && !oncard_rom_en) else $error("lockout");
  a_bank_rom_off: assert property (standalone && bus_addr[10] |-> !oncard_rom_en)
    else $error("bank");
  a_por_blocks: assert property (power_on_init |-> !oncard_ram_en && !oncard_rom_en)
    else $error("por enable");
  a_por_hold: assert property ($fell(rst) |-> power_on_init [*8]) else $error("por");
endmodule
bind mms_memory_select mms_sel_assertions u_mms_sel_assertions (.*);

// >>> bench/mms_other_cards.sv
`timescale 1ns/1ps
// ****
// Other cards and pull-up
// ****
module mms_other_cards (
  // Card drivers and resolved line
  input wire logic ram_card_sel_n_oe, rom_card_sel_n_oe, other_sel,
  output logic shared_card_select_n_i
);
  // Wired-AND of open-drain drivers, high when all released
  assign shared_card_select_n_i =
    !(ram_card_sel_n_oe || rom_card_sel_n_oe || other_sel);
endmodule

// >>> bench/tb_mms_memory_select.sv
`timescale 1ns/1ps
// ****
// Memory select bench
// ****
module tb_mms_memory_select;
  import mms_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, addr_strobe = 1'b0, rom_load = 1'b0, rom_expanded = 1'b1;
  logic read_strobe_n = 1'b1, write_strobe_n = 1'b1, standalone = 1'b0, other_sel = 1'b0;
  logic onboard_ram_select = 1'b0, onboard_rom_select = 1'b0;
  logic ram_card_disable_n = 1'b1, rom_card_disable_n = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00, rdata;
  logic [3:0] status_flags = 4'h0, rom_preset = 4'h9, latched_addr_hi, latched_flags;
  logic [4:0] ram_preset = 5'h15;
  logic shared_card_select_n_i, ram_card_sel_n_o, ram_card_sel_n_oe, rom_card_sel_n_o;
  logic rom_card_sel_n_oe, power_on_init, oncard_ram_en, oncard_rom_en, rdata_valid;
  logic buffered_read_strobe, buffered_write_strobe;
  int num_errors = 0, comparisons = 0;
  // Clock
  initial begin
    forever #20 mclk = ~mclk;
  end
  // Design and far side
  mms_memory_select u_mms_memory_select (.*);
  mms_other_cards u_mms_other_cards (.*);
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  // One strobe cycle with expected strobe and data
  task automatic access(input logic [15:0] a, input bit rd, input logic [7:0] d, input bit s);
    @(posedge mclk);
    {bus_addr, bus_wdata, read_strobe_n, write_strobe_n} <= {a, d, !rd, rd};
    step(3);
    check(rd ? buffered_read_strobe : buffered_write_strobe, s);
    @(posedge mclk);
    {read_strobe_n, write_strobe_n} <= 2'b11;
    step(2);
    if (rd && s) check(rdata, d);
    if (rd && s) check(rdata_valid, 1);
  endtask
  task automatic t_decode;
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk);
      bus_addr <= {i[4:0], 11'h000};
      step(1);
      check({ram_card_sel_n_oe, rom_card_sel_n_oe}, {i == 21, i / 2 == 9});
      check(shared_card_select_n_i, i != 21 && i / 2 != 9);
      check({ram_card_sel_n_o, rom_card_sel_n_o}, 2'b00);
    end
    @(posedge mclk);
    {ram_card_disable_n, rom_card_disable_n, bus_addr} <= {2'b00, 16'ha800};
    step(1);
    check({ram_card_sel_n_oe, shared_card_select_n_i}, 2'b01);
    $display("decode test done");
  endtask
  task automatic t_mem;
    access(16'ha805, 0, 8'h55, 0);
    access(16'h9123, 1, 8'h00, 0);
    @(posedge mclk);
    {ram_card_disable_n, rom_card_disable_n} <= 2'b11;
    access(16'h9123, 0, 8'h00, 0);
    access(16'ha800, 0, 8'h3c, 1);
    access(16'hafff, 0, 8'hc3, 1);
    access(16'ha800, 1, 8'h3c, 1);
    access(16'hafff, 1, 8'hc3, 1);
    $display("memory test done");
  endtask
  task automatic oncard(input logic [15:0] a, input logic [3:0] m, input logic [1:0] e);
    @(posedge mclk);
    {bus_addr, standalone, other_sel, onboard_ram_select, onboard_rom_select} <= {a, m};
    step(4);
    check({oncard_ram_en, oncard_rom_en}, e);
  endtask
  task automatic t_oncard;
    oncard(16'h0010, 4'b0110, 2'b00);
    oncard(16'h0010, 4'b0010, 2'b10);
    oncard(16'h0010, 4'b0001, 2'b01);
    oncard(16'h0410, 4'b1000, 2'b10);
    oncard(16'h0010, 4'b1000, 2'b01);
    @(posedge mclk);
    rom_expanded <= 1'b0;
    oncard(16'h0210, 4'b0001, 2'b00);
    oncard(16'h0010, 4'b0001, 2'b01);
    @(posedge mclk);
    rom_expanded <= 1'b1;
    oncard(16'h0210, 4'b0001, 2'b01);
    $display("on-card test done");
  endtask
  task automatic t_latch;
    @(posedge mclk);
    {bus_addr, status_flags, addr_strobe} <= {16'hc000, 4'h5, 1'b1};
    step(4);
    check({latched_addr_hi, latched_flags}, 8'hc5);
    $display("latch test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reset, power-on window, then scenarios
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    step(POR_CYCLES - 4);
    check(power_on_init, 1);
    step(8);
    check(power_on_init, 0);
    t_decode();
    t_mem();
    t_oncard();
    t_latch();
    print_verdict();
  end
endmodule

// >>> rtl/mms_card_decode.sv
`timescale 1ns/1ps
// Shared card decode: preset match gated by disable, open-drain select
module mms_card_decode #(
  parameter int PW = 5
) (
  // Address and preset
  input wire logic [PW-1:0] addr_hi,
  input wire logic [PW-1:0] preset_code,
  input wire logic card_disable_n,
  // Result
  output logic card_sel,
  output logic sel_n_o,
  output logic sel_n_oe
);
  // Match only when not disabled
  assign card_sel = (addr_hi == preset_code) && card_disable_n;
  // Drive low only while selected, else released
  assign sel_n_o = 1'b0;
  assign sel_n_oe = card_sel;
endmodule

// >>> rtl/mms_memory_select.sv
`timescale 1ns/1ps
// Operation
// - RAM card selected on five-bit preset match
// - Disable input low blocks card selection
// - Select line released unless card selected
// - RAM strobes inactive unless card selected
// - RAM card holds 2048 bytes
// - ROM card: 12-bit address, 4-bit preset
// - ROM card has no write path
// - Card selects wired-AND on common line
// - Common line low locks out on-card memory
// - Common high: RAM/ROM select inputs enable
// - Stand-alone: address bit 10 picks bank
// - Latch top address and status flags
// - On-card 256 RAM, 512/2048 ROM
// - Card makes its own power-on initialise
module mms_memory_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Processor bus
  input wire logic [mms_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [mms_pkg::DATA_W-1:0] bus_wdata,
  input wire logic addr_strobe,
  input wire logic [mms_pkg::FLAG_W-1:0] status_flags,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  // CPU card memory control
  input wire logic standalone,
  input wire logic onboard_ram_select,
  input wire logic onboard_rom_select,
  input wire logic rom_expanded,
  // Shared card select line
  input wire logic shared_card_select_n_i,
  output logic ram_card_sel_n_o,
  output logic ram_card_sel_n_oe,
  output logic rom_card_sel_n_o,
  output logic rom_card_sel_n_oe,
  // Card presets
  input wire logic [mms_pkg::RAM_PRESET_W-1:0] ram_preset,
  input wire logic [mms_pkg::ROM_PRESET_W-1:0] rom_preset,
  input wire logic ram_card_disable_n,
  input wire logic rom_card_disable_n,
  // ROM contents load port
  input wire logic rom_load,
  // Results
  output logic [3:0] latched_addr_hi,
  output logic [mms_pkg::FLAG_W-1:0] latched_flags,
  output logic power_on_init,
  output logic oncard_ram_en,
  output logic oncard_rom_en,
  output logic buffered_read_strobe,
  output logic buffered_write_strobe,
  output logic [mms_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid
);
  import mms_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] rd_s1, rd_s2, wr_s1, wr_s2, as_s1, as_s2, sel_s1, sel_s2;
  always_ff @(posedge mclk) begin
    rd_s1 <= {read_strobe_n, rd_s1[1]};
    wr_s1 <= {write_strobe_n, wr_s1[1]};
  end
  // Two flops per pin; bit 1 of s2 holds the safe value
  always_ff @(posedge mclk) begin
    as_s1 <= {addr_strobe, 1'b0};
    as_s2 <= {as_s1[1], as_s2[1]};
    sel_s1 <= {shared_card_select_n_i, 1'b0};
    sel_s2 <= {sel_s1[1], sel_s2[1]};
    rd_s2 <= {rd_s1[1], rd_s2[1]};
    wr_s2 <= {wr_s1[1], wr_s2[1]};
  end
  logic rd_active, wr_active, as_rise, common_hi;
  assign rd_active = !rd_s2[1];
  assign wr_active = !wr_s2[1];
  assign as_rise = as_s2[1] && !as_s2[0];
  // Undriven line reads high through the pull-up
  assign common_hi = sel_s2[1];

  // ****************************************
  // Power-on initialise
  // ****************************************
  logic [7:0] por_cnt_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      por_cnt_reg <= POR_CNT_RST;
    end else if (por_cnt_reg != 8'(POR_CYCLES)) begin
      por_cnt_reg <= por_cnt_reg + 8'h01;
    end
  end
  assign power_on_init = rst || (por_cnt_reg != 8'(POR_CYCLES));

  // ****************************************
  // Address phase latch
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      latched_addr_hi <= 4'h0;
      latched_flags <= 4'h0;
    end else if (as_rise) begin
      latched_addr_hi <= bus_addr[ADDR_W-1:HI_NIB_LSB];
      latched_flags <= status_flags;
    end
  end

  // ****************************************
  // CPU card on-card select
  // ****************************************
  logic ram_pick, rom_pick, rom_in_range;
  always_comb begin
    if (standalone) begin
      rom_pick = !bus_addr[BANK_BIT];
      ram_pick = bus_addr[BANK_BIT];
    end else begin
      rom_pick = onboard_rom_select;
      ram_pick = onboard_ram_select;
    end
  end
  assign rom_in_range = rom_expanded || (bus_addr[9] == 1'b0);
  assign oncard_ram_en = common_hi && ram_pick && !power_on_init;
  assign oncard_rom_en = common_hi && rom_pick && rom_in_range && !power_on_init;

  // ****************************************
  // RAM and ROM card decode
  // ****************************************
  logic ram_card_sel, rom_card_sel;
  mms_card_decode #(.PW(RAM_PRESET_W)) u_ram_dec (
    .addr_hi(bus_addr[ADDR_W-1:RAM_ADDR_W]),
    .preset_code(ram_preset),
    .card_disable_n(ram_card_disable_n),
    .card_sel(ram_card_sel),
    .sel_n_o(ram_card_sel_n_o),
    .sel_n_oe(ram_card_sel_n_oe)
  );
  mms_card_decode #(.PW(ROM_PRESET_W)) u_rom_dec (
    .addr_hi(bus_addr[ADDR_W-1:ROM_ADDR_W]),
    .preset_code(rom_preset),
    .card_disable_n(rom_card_disable_n),
    .card_sel(rom_card_sel),
    .sel_n_o(rom_card_sel_n_o),
    .sel_n_oe(rom_card_sel_n_oe)
  );
  // Strobes held inactive unless selected
  assign buffered_read_strobe = ram_card_sel && rd_active;
  assign buffered_write_strobe = ram_card_sel && wr_active;

  // ****************************************
  // Memory arrays
  // ****************************************
  logic [DATA_W-1:0] ram_card_mem [RAM_DEPTH];
  logic [DATA_W-1:0] rom_card_mem [ROM_DEPTH];
  logic [DATA_W-1:0] oncard_ram_mem [ONCARD_RAM_BYTES];
  logic [DATA_W-1:0] oncard_rom_mem [ONCARD_ROM_BYTES];
  always_ff @(posedge mclk) begin
    if (buffered_write_strobe) begin
      ram_card_mem[bus_addr[RAM_ADDR_W-1:0]] <= bus_wdata;
    end
    if (oncard_ram_en && wr_active) begin
      oncard_ram_mem[bus_addr[7:0]] <= bus_wdata;
    end
  end
  // ROM arrays written only by the load port, never the bus
  always_ff @(posedge mclk) begin
    if (rom_load && rom_card_sel) begin
      rom_card_mem[bus_addr[ROM_ADDR_W-1:0]] <= bus_wdata;
    end
    if (rom_load && oncard_rom_en) begin
      oncard_rom_mem[bus_addr[RAM_ADDR_W-1:0]] <= bus_wdata;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= DATA_RST;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= rd_active && (ram_card_sel || rom_card_sel || oncard_ram_en || oncard_rom_en);
      if (rd_active && ram_card_sel) begin
        rdata <= ram_card_mem[bus_addr[RAM_ADDR_W-1:0]];
      end else if (rd_active && rom_card_sel) begin
        rdata <= rom_card_mem[bus_addr[ROM_ADDR_W-1:0]];
      end else if (rd_active && oncard_ram_en) begin
        rdata <= oncard_ram_mem[bus_addr[7:0]];
      end else if (rd_active && oncard_rom_en) begin
        rdata <= oncard_rom_mem[bus_addr[RAM_ADDR_W-1:0]];
      end
    end
  end
endmodule

// >>> rtl/mms_pkg.sv
package mms_pkg;
  // ****************************************
  // Card address decode
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int RAM_PRESET_W = 5;
  localparam int ROM_PRESET_W = 4;
  localparam int RAM_ADDR_W = 11;
  localparam int ROM_ADDR_W = 12;
  localparam int RAM_DEPTH = 2048;
  localparam int ROM_DEPTH = 4096;
  localparam int DATA_W = 8;
  localparam int ONCARD_RAM_BYTES = 256;
  localparam int ONCARD_ROM_BYTES = 2048;
  localparam int ONCARD_ROM_STD_BYTES = 512;
  localparam int BANK_BIT = 10;
  localparam int HI_NIB_LSB = 12;
  localparam int FLAG_W = 4;
  // ****************************************
  // Power-on initialise timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int POR_US = 10;
  localparam int POR_CYCLES = POR_US * CLK_MHZ;
  localparam logic [7:0] POR_CNT_RST = 8'h00;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
endpackage
